// ==== hdl/dpll_reference_selector.sv ====
// Reference selection, holdover control and phase build-out for one DPLL with two inputs.
`include "refsel_map.svh"

// Behaviour
// RULE_01 - Each input has priority 0 to 7; 0 never chosen, 1 most preferred. Manual modes still take a valid priority-0 input.
// RULE_02 - Equal priorities favour input zero over input one.
// RULE_03 - The multiplexer chooses between exactly two reference inputs.
// RULE_04 - Choice is automatic by priority, or manual by register or select pin.
// RULE_05 - Selected reference shows in a status register and on configurable status pins.
// RULE_06 - Auto revertive: always best valid input, switch at once to better one.
// RULE_07 - Auto non-revertive: keep current input until it turns invalid.
// RULE_08 - Manual modes take the reference from register or pin, as configured.
// RULE_09 - Manual fallback: manual while valid, else best valid, else holdover or free-run.
// RULE_10 - Manual holdover: manual while valid, else holdover or free-run, no other input.
// RULE_11 - Manual modes leave holdover once the selected reference is valid again.
// RULE_12 - Without hitless switching the phase step passes, smoothed only by the loop.
// RULE_13 - Cancellation without slew keeps the absorbed offset indefinitely as build-out.
// RULE_14 - Inputs count as frequency-locked at zero offset or integer-related frequencies.
// RULE_15 - Slew enabled removes build-out by at most step limit per timer interval.
// RULE_16 - Slew limits also apply on lock acquisition and unlocked-frequency switches.
// RULE_17 - Both functions off: offset passes to output at loop bandwidth rate.
// RULE_18 - The source keeps gaps within one divided reference period.
// RULE_19 - Software never enables ppm and phase-valid detectors on one input together.
// RULE_20 - Oscillator loss flag clears between 9 MHz and 160 MHz, set otherwise.
// RULE_21 - Bypass makes the control machine treat the oscillator as valid.
// RULE_22 - Bypass leaves the loss flag unchanged and visible in status and on pins.
// RULE_23 - An input is valid only after monitors stay clear for the validation time.
// RULE_24 - Selection is re-evaluated every cycle and changes at most once per cycle.
module dpll_reference_selector
    import refsel_pkg::*;
#(
    parameter int XO_GATE_CYCLES = `XO_GATE_US * (`CLK_HZ / 1000000)
) (
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [7:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic REF0_MON_CLEAR_IN,
    input wire logic REF1_MON_CLEAR_IN,
    input wire logic FREQ_LOCKED_IN,
    input wire logic HISTORY_VALID_IN,
    input wire logic [15:0] PHASE_OFFSET_IN,
    input wire logic SEL_PIN_IN,
    input wire logic XO_TICK_IN,
    output logic SEL_REF_OUT,
    output logic REF_ACTIVE_OUT,
    output logic HOLDOVER_OUT,
    output logic FREERUN_OUT,
    output logic SWITCH_OUT,
    output logic XO_VALID_OUT,
    output logic [1:0] STATUS_PIN_OUT,
    output logic [15:0] PHASE_BUILDOUT_OUT
);

    // Cycles of the core clock in one microsecond tick.
    localparam int CYC_PER_US = `TICK_US * (`CLK_HZ / 1000000);
    localparam logic [4:0] TICK_LAST = 5'(CYC_PER_US - 1);

    sel_state_t r;
    sel_state_t next_r;
    logic tick_us;
    logic [1:0] ref_valid;
    logic xo_loss;

    // Microsecond enable pulse shared by the timers.
    assign tick_us = (r.tick_cnt == TICK_LAST);

    // Validation timers, one for each reference input.
    ref_qualifier u_qual0 (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .tick_us_in(tick_us),
        .flags_clear_in(REF0_MON_CLEAR_IN),
        .timer_us_in(r.cfg.vtimer[`VT0_LSB +: 16]),
        .valid_out(ref_valid[0])
    );

    ref_qualifier u_qual1 (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .tick_us_in(tick_us),
        .flags_clear_in(REF1_MON_CLEAR_IN),
        .timer_us_in(r.cfg.vtimer[`VT1_LSB +: 16]),
        .valid_out(ref_valid[1])
    );

    // Oscillator coarse frequency monitor.
    xo_freq_monitor #(
        .GATE_CYCLES(XO_GATE_CYCLES)
    ) u_xo_mon (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .xo_tick_in(XO_TICK_IN),
        .loss_out(xo_loss)
    );

    // Returns {found, index} of the best eligible input.
    function automatic logic [1:0] pick_best(input logic [1:0] valid, input logic [2:0] p0,
                                             input logic [2:0] p1);
        logic e0;
        logic e1;
        e0 = valid[0] && (p0 != 3'h0); // [RULE_01]
        e1 = valid[1] && (p1 != 3'h0); // [RULE_01]
        if (e0 && e1) begin
            pick_best = {1'b1, (p1 < p0)}; // [RULE_02]
        end else if (e0) begin
            pick_best = 2'b10;
        end else if (e1) begin
            pick_best = 2'b11;
        end else begin
            pick_best = 2'b00;
        end
    endfunction

    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    // Next state: register file, pin synchroniser, selection machine and phase build-out.
    always_comb begin
        logic [2:0] p0;
        logic [2:0] p1;
        logic man_sel;
        logic [1:0] best;
        logic [1:0] tgt;
        logic cur_ok;
        logic acq;
        logic slew_en;
        logic [15:0] step_lim;
        logic [15:0] step_tmr;
        logic signed [16:0] b17;
        logic signed [16:0] lim17;
        logic signed [16:0] nb;
        logic [31:0] status;
        sel_mode_t mode;
        p0 = 3'h0;
        p1 = 3'h0;
        man_sel = 1'b0;
        best = 2'b00;
        tgt = 2'b00;
        cur_ok = 1'b0;
        acq = 1'b0;
        slew_en = 1'b0;
        step_lim = 16'h0000;
        step_tmr = 16'h0000;
        b17 = 17'sh00000;
        lim17 = 17'sh00000;
        nb = 17'sh00000;
        status = 32'h0000_0000;
        mode = MODE_AUTO_REV;
        next_r = r;
        next_r.switch_pulse = 1'b0;

        // Microsecond divider.
        next_r.tick_cnt = tick_us ? 5'h00 : r.tick_cnt + 5'h01;

        // Select pin passes three flops; the level moves when the last two agree.
        next_r.pin_sync = {r.pin_sync[1:0], SEL_PIN_IN};
        if (r.pin_sync[1] == r.pin_sync[2]) begin
            next_r.pin_lvl = r.pin_sync[2];
        end

        // Decode configuration fields.
        mode = sel_mode_t'(r.cfg.control[`CTL_MODE_LSB +: 2]);
        p0 = r.cfg.prio[`PRI0_LSB +: 3];
        p1 = r.cfg.prio[`PRI1_LSB +: 3];
        slew_en = r.cfg.control[`CTL_SLEW_EN];
        step_lim = r.cfg.slew[`SLEW_LIMIT_LSB +: 16];
        step_tmr = r.cfg.slew[`SLEW_TIMER_LSB +: 16];
        man_sel = r.cfg.control[`CTL_PIN_CTRL] ? r.pin_lvl
                                               : r.cfg.control[`CTL_MAN_SEL]; // [RULE_08]

        // The oscillator counts as valid under bypass whatever the monitor says.
        next_r.xo_valid = r.cfg.control[`CTL_XO_BYPASS] || !xo_loss; // [RULE_21]

        // Candidate for this cycle, chosen afresh every cycle.
        best = pick_best(ref_valid, p0, p1); // [RULE_04]
        cur_ok = (r.state == ST_LOCKED) && ref_valid[r.sel]
                 && ((r.sel ? p1 : p0) != 3'h0);
        case (mode)
            MODE_AUTO_REV: begin
                tgt = best; // [RULE_06]
            end
            MODE_AUTO_NONREV: begin
                tgt = cur_ok ? {1'b1, r.sel} : best; // [RULE_07]
            end
            MODE_MAN_FALLBACK: begin
                if (ref_valid[man_sel]) begin
                    tgt = {1'b1, man_sel}; // [RULE_09] [RULE_11]
                end else begin
                    tgt = cur_ok ? {1'b1, r.sel} : best; // [RULE_09]
                end
            end
            MODE_MAN_HOLDOVER: begin
                tgt = ref_valid[man_sel] ? {1'b1, man_sel} : 2'b00; // [RULE_10] [RULE_11]
            end
            default: begin
                tgt = 2'b00;
            end
        endcase
        if (!r.xo_valid) begin
            tgt = 2'b00;
        end

        // Selection machine; at most one change of reference per cycle.
        case (r.state)
            ST_LOCKED: begin
                if (tgt[1]) begin
                    if (tgt[0] != r.sel) begin
                        next_r.sel = tgt[0]; // [RULE_03] [RULE_24]
                        next_r.switch_pulse = 1'b1;
                    end
                end else if (r.xo_valid && HISTORY_VALID_IN) begin
                    next_r.state = ST_HOLDOVER; // [RULE_09] [RULE_10]
                end else begin
                    next_r.state = ST_FREERUN; // [RULE_09] [RULE_10]
                end
            end
            ST_HOLDOVER: begin
                if (!r.xo_valid) begin
                    next_r.state = ST_FREERUN;
                end else if (tgt[1]) begin
                    next_r.state = ST_LOCKED; // [RULE_11]
                    next_r.sel = tgt[0];
                    next_r.switch_pulse = 1'b1;
                    acq = 1'b1;
                end
            end
            default: begin
                if (tgt[1]) begin
                    next_r.state = ST_LOCKED;
                    next_r.sel = tgt[0];
                    next_r.switch_pulse = 1'b1;
                    acq = 1'b1;
                end
            end
        endcase

        // Phase build-out at a switch or at lock acquisition.
        if (next_r.switch_pulse) begin
            next_r.slew_cnt = 16'h0000;
            if (!acq && r.cfg.control[`CTL_CANCEL_EN] && FREQ_LOCKED_IN) begin
                next_r.buildout = PHASE_OFFSET_IN; // [RULE_13] [RULE_14]
            end else if (slew_en) begin
                next_r.buildout = PHASE_OFFSET_IN; // [RULE_16]
            end else begin
                next_r.buildout = 16'sh0000; // [RULE_12] [RULE_17]
            end
        end else if (slew_en && r.buildout != 16'sh0000 && tick_us) begin
            // Remove the build-out by bounded steps, one per timer interval.
            if (r.slew_cnt + 16'h0001 >= step_tmr) begin
                next_r.slew_cnt = 16'h0000;
                b17 = {r.buildout[15], r.buildout};
                lim17 = {1'b0, step_lim};
                if (b17 > lim17) begin
                    nb = b17 - lim17; // [RULE_15]
                end else if (b17 < -lim17) begin
                    nb = b17 + lim17; // [RULE_15]
                end else begin
                    nb = 17'sh00000;
                end
                next_r.buildout = nb[15:0];
            end else begin
                next_r.slew_cnt = r.slew_cnt + 16'h0001;
            end
        end

        // Status word; the loss flag is shown as measured, bypass or not.
        status[`ST_SEL] = r.sel; // [RULE_05]
        status[`ST_ACTIVE] = (r.state == ST_LOCKED);
        status[`ST_HOLDOVER] = (r.state == ST_HOLDOVER);
        status[`ST_FREERUN] = (r.state == ST_FREERUN);
        status[`ST_XO_LOSS] = xo_loss; // [RULE_22]
        status[`ST_XO_VALID] = r.xo_valid;
        status[`ST_VALID0] = ref_valid[0];
        status[`ST_VALID1] = ref_valid[1];
        status[`ST_SLEWING] = slew_en && (r.buildout != 16'sh0000);

        // Status pins carry the group picked in the control register.
        case (r.cfg.control[`CTL_STAT_SEL_LSB +: 2])
            2'h0: next_r.status_pin = {r.sel, r.state == ST_LOCKED}; // [RULE_05]
            2'h1: next_r.status_pin = {r.xo_valid, xo_loss}; // [RULE_22]
            2'h2: next_r.status_pin = ref_valid;
            default: next_r.status_pin = {r.state == ST_FREERUN, r.state == ST_HOLDOVER};
        endcase

        // Avalon slave: waitrequest drops for one cycle; a write lands at that edge.
        if (r.waitreq) begin
            if (AVS_READ_IN || AVS_WRITE_IN) begin
                next_r.waitreq = 1'b0;
                if (AVS_ADDRESS_IN == `OFF_CONTROL) begin
                    next_r.rdata = r.cfg.control;
                end else if (AVS_ADDRESS_IN == `OFF_PRIORITY) begin
                    next_r.rdata = r.cfg.prio;
                end else if (AVS_ADDRESS_IN == `OFF_SLEW) begin
                    next_r.rdata = r.cfg.slew;
                end else if (AVS_ADDRESS_IN == `OFF_VALID_TIMER) begin
                    next_r.rdata = r.cfg.vtimer;
                end else if (AVS_ADDRESS_IN == `OFF_STATUS) begin
                    next_r.rdata = status;
                end else if (AVS_ADDRESS_IN == `OFF_BUILDOUT) begin
                    next_r.rdata = {{16{r.buildout[15]}}, r.buildout};
                end else begin
                    next_r.rdata = 32'h0000_0000;
                end
            end
        end else begin
            next_r.waitreq = 1'b1;
            if (AVS_WRITE_IN) begin
                if (AVS_ADDRESS_IN == `OFF_CONTROL) begin
                    next_r.cfg.control = merge(r.cfg.control, AVS_WRITEDATA_IN,
                                               AVS_BYTEENABLE_IN) & 32'h0000_037F;
                end else if (AVS_ADDRESS_IN == `OFF_PRIORITY) begin
                    next_r.cfg.prio = merge(r.cfg.prio, AVS_WRITEDATA_IN,
                                            AVS_BYTEENABLE_IN) & 32'h0000_0077; // [RULE_01]
                end else if (AVS_ADDRESS_IN == `OFF_SLEW) begin
                    next_r.cfg.slew = merge(r.cfg.slew, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                end else if (AVS_ADDRESS_IN == `OFF_VALID_TIMER) begin
                    next_r.cfg.vtimer = merge(r.cfg.vtimer, AVS_WRITEDATA_IN,
                                              AVS_BYTEENABLE_IN);
                end
            end
        end
    end

    // State register with documented reset values.
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            r <= '0;
            r.cfg.control <= `RST_CONTROL;
            r.cfg.prio <= `RST_PRIORITY;
            r.cfg.slew <= `RST_SLEW;
            r.cfg.vtimer <= `RST_VALID_TIMER;
            r.state <= ST_FREERUN;
            r.waitreq <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register.
    assign AVS_READDATA_OUT = r.rdata;
    assign AVS_WAITREQUEST_OUT = r.waitreq;
    assign SEL_REF_OUT = r.sel;
    assign REF_ACTIVE_OUT = (r.state == ST_LOCKED);
    assign HOLDOVER_OUT = (r.state == ST_HOLDOVER);
    assign FREERUN_OUT = (r.state == ST_FREERUN);
    assign SWITCH_OUT = r.switch_pulse;
    assign XO_VALID_OUT = r.xo_valid;
    assign STATUS_PIN_OUT = r.status_pin;
    assign PHASE_BUILDOUT_OUT = r.buildout;

endmodule // dpll_reference_selector

// ==== hdl/ref_qualifier.sv ====
// Validation timer that qualifies one reference once its monitors stay clear long enough.
module ref_qualifier
    import refsel_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tick_us_in,
    input wire logic flags_clear_in,
    input wire logic [15:0] timer_us_in,
    output logic valid_out
);

    qual_state_t r;
    qual_state_t next_r;

    // Any flag restarts the wait; the input turns valid after the programmed clear time.
    always_comb begin
        next_r = r;
        if (!flags_clear_in) begin
            next_r.cnt = 16'h0000; // [RULE_23]
            next_r.valid = 1'b0;
        end else if (!r.valid) begin
            if (r.cnt >= timer_us_in) begin
                next_r.valid = 1'b1; // [RULE_23]
            end else if (tick_us_in) begin
                next_r.cnt = r.cnt + 16'h0001;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign valid_out = r.valid;

endmodule // ref_qualifier

// ==== hdl/refsel_map.svh ====
// Register offsets, field positions, reset values and timing figures of the reference selector.
`ifndef REFSEL_MAP_SVH
`define REFSEL_MAP_SVH

// Byte offsets of the registers on the Avalon-MM slave.
`define OFF_CONTROL 8'h00
`define OFF_PRIORITY 8'h04
`define OFF_SLEW 8'h08
`define OFF_VALID_TIMER 8'h0C
`define OFF_STATUS 8'h10
`define OFF_BUILDOUT 8'h14

// Field positions in the control register.
`define CTL_MODE_LSB 0
`define CTL_MAN_SEL 2
`define CTL_PIN_CTRL 3
`define CTL_CANCEL_EN 4
`define CTL_SLEW_EN 5
`define CTL_XO_BYPASS 6
`define CTL_STAT_SEL_LSB 8

// Field positions in the priority, slew and validation timer registers.
`define PRI0_LSB 0
`define PRI1_LSB 4
`define SLEW_LIMIT_LSB 0
`define SLEW_TIMER_LSB 16
`define VT0_LSB 0
`define VT1_LSB 16

// Field positions in the status register.
`define ST_SEL 0
`define ST_ACTIVE 1
`define ST_HOLDOVER 2
`define ST_FREERUN 3
`define ST_XO_LOSS 4
`define ST_XO_VALID 5
`define ST_VALID0 6
`define ST_VALID1 7
`define ST_SLEWING 8

// Reset values of the writable registers.
`define RST_CONTROL 32'h0000_0000
`define RST_PRIORITY 32'h0000_0021
`define RST_SLEW 32'h000A_0010
`define RST_VALID_TIMER 32'h0064_0064

// Timing figures: core clock rate, microsecond tick and oscillator monitor window.
`define CLK_HZ 20000000
`define TICK_US 1
`define XO_MIN_HZ 9000000
`define XO_MAX_HZ 160000000
`define XO_PRESCALE 64
`define XO_GATE_US 1000

`endif

// ==== hdl/refsel_pkg.sv ====
// Types shared by the reference selector and its helper modules.
package refsel_pkg;

    // Reference selection modes held in the control register.
    typedef enum logic [1:0] {
        MODE_AUTO_REV,
        MODE_AUTO_NONREV,
        MODE_MAN_FALLBACK,
        MODE_MAN_HOLDOVER
    } sel_mode_t;

    // Operating state of the DPLL as seen by the selector.
    typedef enum logic [1:0] {
        ST_FREERUN,
        ST_LOCKED,
        ST_HOLDOVER
    } pll_state_t;

    // State of one reference validation timer.
    typedef struct packed {
        logic [15:0] cnt;
        logic valid;
    } qual_state_t;

    // State of the oscillator coarse frequency monitor.
    typedef struct packed {
        logic [2:0] sync;
        logic lvl;
        logic [15:0] gate_cnt;
        logic [15:0] edge_cnt;
        logic loss;
    } xo_state_t;

    // Configuration carried from the register file into the selection logic.
    typedef struct packed {
        logic [31:0] control;
        logic [31:0] prio;
        logic [31:0] slew;
        logic [31:0] vtimer;
    } cfg_t;

    // State of the selector top level.
    typedef struct packed {
        cfg_t cfg;
        logic [2:0] pin_sync;
        logic pin_lvl;
        pll_state_t state;
        logic sel;
        logic switch_pulse;
        logic xo_valid;
        logic signed [15:0] buildout;
        logic [4:0] tick_cnt;
        logic [15:0] slew_cnt;
        logic waitreq;
        logic [31:0] rdata;
        logic [1:0] status_pin;
    } sel_state_t;

endpackage

// ==== hdl/xo_freq_monitor.sv ====
// Coarse frequency monitor for the prescaled oscillator input.
`include "refsel_map.svh"
module xo_freq_monitor
    import refsel_pkg::*;
#(
    parameter int GATE_CYCLES = 20000
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic xo_tick_in,
    output logic loss_out
);

    // Edge counts in one window that bound the accepted oscillator band.
    localparam longint MIN_CNT_L = longint'(`XO_MIN_HZ) / `XO_PRESCALE * GATE_CYCLES / `CLK_HZ;
    localparam longint MAX_CNT_L = longint'(`XO_MAX_HZ) / `XO_PRESCALE * GATE_CYCLES / `CLK_HZ;
    localparam logic [15:0] MIN_CNT = 16'(MIN_CNT_L);
    localparam logic [15:0] MAX_CNT = 16'(MAX_CNT_L);
    localparam logic [15:0] GATE_LAST = 16'(GATE_CYCLES - 1);

    xo_state_t r;
    xo_state_t next_r;

    // Synchronise the pin, count accepted rising edges and judge the band at window end.
    always_comb begin
        next_r = r;
        next_r.sync = {r.sync[1:0], xo_tick_in};
        if (r.sync[1] == r.sync[2] && r.sync[2] != r.lvl) begin
            next_r.lvl = r.sync[2];
            if (r.sync[2] && r.edge_cnt != 16'hFFFF) begin
                next_r.edge_cnt = r.edge_cnt + 16'h0001;
            end
        end
        if (r.gate_cnt == GATE_LAST) begin
            next_r.gate_cnt = 16'h0000;
            next_r.edge_cnt = 16'h0000;
            next_r.loss = !(r.edge_cnt >= MIN_CNT && r.edge_cnt <= MAX_CNT); // [RULE_20]
        end else begin
            next_r.gate_cnt = r.gate_cnt + 16'h0001;
        end
    end

    // State register; the flag reports loss until the first window has been judged.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
            r.loss <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign loss_out = r.loss;

endmodule // xo_freq_monitor

// ==== tb/dpll_reference_selector_tb.sv ====
// Self-checking bench for the reference selector.
`include "refsel_map.svh"
module dpll_reference_selector_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, rd = 0, wr = 0, hist = 0, pin = 0, flk = 0;
    logic [15:0] po = 16'h0123, bo;
    logic [7:0] ad = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [1:0] want = 2'h0, sp;
    logic wrq, sel, act, hold, free, sw, xov, c0, c1, xt;
    int miscompares = 0, n_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    dpll_reference_selector #(.XO_GATE_CYCLES(2000)) dut_u (.CLOCK_IN(clk), .SYS_RST_IN(rst),
        .AVS_ADDRESS_IN(ad), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wrq),
        .REF0_MON_CLEAR_IN(c0), .REF1_MON_CLEAR_IN(c1), .FREQ_LOCKED_IN(flk),
        .HISTORY_VALID_IN(hist), .PHASE_OFFSET_IN(po), .SEL_PIN_IN(pin),
        .XO_TICK_IN(xt), .SEL_REF_OUT(sel), .REF_ACTIVE_OUT(act), .HOLDOVER_OUT(hold),
        .FREERUN_OUT(free), .SWITCH_OUT(sw), .XO_VALID_OUT(xov), .STATUS_PIN_OUT(sp),
        .PHASE_BUILDOUT_OUT(bo));
    ref_source_model ps_u (.clk_in(clk), .want_in(want), .clear0_out(c0), .clear1_out(c1),
        .xo_tick_out(xt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w; wr <= w; ad <= a; wd <= d;
        do @(posedge clk); while (wrq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic settle(input logic [1:0] w);
        want <= w;
        repeat (8) @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_regs;
        bus(0, `OFF_PRIORITY, 0); chk(q, `RST_PRIORITY);
        bus(0, 8'h20, 0); chk(q, 0);
        bus(1, `OFF_VALID_TIMER, 0);
    endtask
    task automatic t_xo;
        repeat (4500) @(posedge clk);
        chk(xov, 1);
        bus(0, `OFF_STATUS, 0); chk(q[`ST_XO_LOSS], 0);
    endtask
    task automatic t_rev;
        settle(2'h2); chk({act, sel, sp}, 4'hF);
        settle(2'h3); chk(sel, 0);
        chk(bo, 0);
        bus(1, `OFF_PRIORITY, 32'h12); settle(2'h3); chk(sel, 1);
        bus(1, `OFF_PRIORITY, 32'h11); settle(2'h3); chk(sel, 0);
    endtask
    task automatic t_nonrev;
        bus(1, `OFF_CONTROL, 1); settle(2'h2); chk(sel, 1);
        bus(1, `OFF_PRIORITY, 32'h21); settle(2'h3); chk(sel, 1);
    endtask
    task automatic t_prio0;
        bus(1, `OFF_CONTROL, 0); bus(1, `OFF_PRIORITY, 32'h10);
        settle(2'h3); chk(sel, 1);
        settle(2'h1); chk({act, free}, 2'h1);
    endtask
    task automatic t_manual;
        hist <= 1'b1;
        bus(1, `OFF_CONTROL, 3); settle(2'h3); chk({act, sel}, 2'h2);
        settle(2'h2); chk({hold, sel}, 2'h2);
        settle(2'h3); chk({act, sel}, 2'h2);
        bus(1, `OFF_PRIORITY, 32'h21); bus(1, `OFF_CONTROL, 6);
        settle(2'h3); chk(sel, 1);
        settle(2'h1); chk({act, sel}, 2'h2);
        pin <= 1'b1; bus(1, `OFF_CONTROL, 32'hA); settle(2'h3); chk(sel, 1);
    endtask
    // Build-out kept by cancellation, then slewed away in bounded steps.
    task automatic t_phase;
        flk <= 1'b1; bus(1, `OFF_CONTROL, 32'h150); settle(2'h3);
        chk({bo, sp}, {16'h0123, 2'h2});
        bus(1, `OFF_CONTROL, 32'h170); repeat (250) @(posedge clk);
        chk(bo, 16'h0113);
        repeat (4000) @(posedge clk); chk(bo, 0);
        settle(2'h0); settle(2'h3); chk(bo, 16'h0123);
    endtask
    // Cycle ceiling that cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs(); t_xo(); t_rev(); t_nonrev(); t_prio0(); t_manual(); t_phase();
        test_done();
    end
endmodule // dpll_reference_selector_tb

// ==== tb/ref_source_model.sv ====
// Reference sources: one monitor-clear level per input and a prescaled oscillator tick.
module ref_source_model (
    input wire logic clk_in,
    input wire logic [1:0] want_in,
    output logic clear0_out,
    output logic clear1_out,
    output logic xo_tick_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] div;
    initial {div, clear0_out, clear1_out, xo_tick_out} = 7'h00;
    // Clears are steady levels, so no gap outlasts one divided period.
    always @(posedge clk_in) begin
        clear0_out <= want_in[0];
        clear1_out <= want_in[1];
        div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
        if (div == 4'h9) xo_tick_out <= ~xo_tick_out;
    end
endmodule // ref_source_model

// ==== tb/refsel_properties.sv ====
// Concurrent checks on the reference selector ports.
module refsel_properties (
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic REF0_MON_CLEAR_IN,
    input wire logic REF1_MON_CLEAR_IN,
    input wire logic SEL_REF_OUT,
    input wire logic REF_ACTIVE_OUT,
    input wire logic HOLDOVER_OUT,
    input wire logic FREERUN_OUT,
    input wire logic SWITCH_OUT,
    input wire logic XO_VALID_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Exactly one operating state is reported at any time.
    a_one_state: assert property ($onehot({REF_ACTIVE_OUT, HOLDOVER_OUT, FREERUN_OUT}))
        else $error("state outputs not one-hot");
    a_sel_qualified: assert property (REF_ACTIVE_OUT |->
        (SEL_REF_OUT ? $past(REF1_MON_CLEAR_IN, 2) : $past(REF0_MON_CLEAR_IN, 2)))
        else $error("locked to an unqualified input");
    a_sel_pulse: assert property ($changed(SEL_REF_OUT) |-> SWITCH_OUT)
        else $error("selection moved without switch pulse");
    a_wait_once: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low longer than one cycle");
    a_idle_wait: assert property (!AVS_READ_IN && !AVS_WRITE_IN |-> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low without a request");
    a_lock_xo: assert property (REF_ACTIVE_OUT |-> $past(XO_VALID_OUT))
        else $error("locked while oscillator invalid");
    a_no_ref: assert property ((!REF0_MON_CLEAR_IN && !REF1_MON_CLEAR_IN)[*3] |->
        !REF_ACTIVE_OUT) else $error("locked with no clear input");
    a_hold_entry: assert property ($rose(HOLDOVER_OUT) |-> $past(REF_ACTIVE_OUT))
        else $error("holdover entered from free-run");
endmodule // refsel_properties
bind dpll_reference_selector refsel_properties chk_u (.CLOCK_IN, .SYS_RST_IN, .AVS_READ_IN,
    .AVS_WRITE_IN, .AVS_WAITREQUEST_OUT, .REF0_MON_CLEAR_IN, .REF1_MON_CLEAR_IN, .SEL_REF_OUT,
    .REF_ACTIVE_OUT, .HOLDOVER_OUT, .FREERUN_OUT, .SWITCH_OUT, .XO_VALID_OUT);
